/* File: gpc_top.sv */
/*
 * gpc_top: three-port general-purpose I/O block behind a classic Wishbone
 * slave.
 * assumes: one clock, synchronous reset, pins already synchronous.
 */
`timescale 1ns/1ps
module gpc_top import gpc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	input wire logic [GPC_PORTS*GPC_PINS-1:0] pin_i,
	output logic [GPC_PORTS*GPC_PINS-1:0] pin_o,
	output logic [GPC_PORTS*GPC_PINS-1:0] pin_oe_o,
	output logic [2*GPC_SEL_PINS-1:0] p1_func_o,
	output logic [2*GPC_SEL_PINS-1:0] p2_func_o
);
	// ==========================================================
	// address decode
	wire req = cyc_i & stb_i & ~ack_o & ~err_o;
	wire hit_f1 = adr_i == GPC_P1_FSEL;
	wire hit_f2 = adr_i == GPC_P2_FSEL;
	wire [2:0] hit_dat = {adr_i == GPC_P2_DAT, adr_i == GPC_P1_DAT,
		adr_i == GPC_P0_DAT};
	wire [2:0] hit_set = {adr_i == GPC_P2_SET, adr_i == GPC_P1_SET,
		adr_i == GPC_P0_SET};
	wire [2:0] hit_clr = {adr_i == GPC_P2_CLR, adr_i == GPC_P1_CLR,
		adr_i == GPC_P0_CLR};
	wire mapped = hit_f1 | hit_f2 | (|hit_dat) | (|hit_set) | (|hit_clr);
	// writes act once, in the cycle the request is taken
	wire wr = req & we_i & mapped;

	// ==========================================================
	// function select
	logic [31:0] f1_val;
	logic [31:0] f2_val;
	gpc_fsel u_f1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr & hit_f1),
		.sel_i(sel_i),
		.wdata_i(dat_i),
		.value_o(f1_val),
		.func_o(p1_func_o)
	);
	gpc_fsel u_f2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(wr & hit_f2),
		.sel_i(sel_i),
		.wdata_i(dat_i),
		.value_o(f2_val),
		.func_o(p2_func_o)
	);

	// ==========================================================
	// ports
	logic [31:0] port_dat [GPC_PORTS];
	genvar p;
	for (p = 0; p < GPC_PORTS; p++) begin : g_port
		gpc_port #(.PINS(GPC_PINS)) u_port (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.dat_we_i(wr & hit_dat[p]),
			.set_we_i(wr & hit_set[p]),
			.clr_we_i(wr & hit_clr[p]),
			.sel_i(sel_i),
			.wdata_i(dat_i),
			.pin_i(pin_i[p*GPC_PINS +: GPC_PINS]),
			.pin_o(pin_o[p*GPC_PINS +: GPC_PINS]),
			.pin_oe_o(pin_oe_o[p*GPC_PINS +: GPC_PINS]),
			.dat_o(port_dat[p])
		);
	end

	// ==========================================================
	// read mux; set and clear read as zero
	wire [31:0] rd_val = hit_f1 ? f1_val :
		hit_f2 ? f2_val :
		hit_dat[0] ? port_dat[0] :
		hit_dat[1] ? port_dat[1] :
		hit_dat[2] ? port_dat[2] : GPC_ZERO;

	// ==========================================================
	// answer: one cycle after the request, unmapped gives err
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= GPC_ZERO;
		end else begin
			ack_o <= req & mapped;
			err_o <= req & ~mapped;
			dat_o <= (req & ~we_i) ? rd_val : GPC_ZERO;
		end
	end

	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_set_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && (|hit_set || |hit_clr)) |=> dat_o == GPC_ZERO)
		else $error("set or clear read not zero");
	a_fsel_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !we_i && hit_f1) |=> (dat_o & ~GPC_FSEL_MASK) == '0)
		else $error("reserved select bits read non-zero");
endmodule // gpc_top

/* File: gpc_pkg.sv */
/*
 * gpc_pkg: register map, field layout and reset values of the three-port
 * general-purpose I/O block.
 * assumes: a 32-bit classic Wishbone slave decodes byte addresses.
 */
package gpc_pkg;
	// ==========================================================
	// geometry
	localparam int GPC_PORTS = 3;
	localparam int GPC_PINS = 8;
	localparam int GPC_SEL_PINS = 7;
	// ==========================================================
	// byte addresses
	localparam logic [31:0] GPC_P1_FSEL = 32'hffff0d04;
	localparam logic [31:0] GPC_P2_FSEL = 32'hffff0d08;
	localparam logic [31:0] GPC_P0_DAT = 32'hffff0d20;
	localparam logic [31:0] GPC_P0_SET = 32'hffff0d24;
	localparam logic [31:0] GPC_P0_CLR = 32'hffff0d28;
	localparam logic [31:0] GPC_P1_DAT = 32'hffff0d30;
	localparam logic [31:0] GPC_P1_SET = 32'hffff0d34;
	localparam logic [31:0] GPC_P1_CLR = 32'hffff0d38;
	localparam logic [31:0] GPC_P2_DAT = 32'hffff0d40;
	localparam logic [31:0] GPC_P2_SET = 32'hffff0d44;
	localparam logic [31:0] GPC_P2_CLR = 32'hffff0d48;
	// ==========================================================
	// field positions
	localparam int GPC_DIR_LSB = 24;
	localparam int GPC_OUT_LSB = 16;
	localparam int GPC_RST_LSB = 8;
	localparam int GPC_IN_LSB = 0;
	localparam int GPC_FSEL_STRIDE = 4;
	localparam logic [31:0] GPC_FSEL_MASK = 32'h03333333;
	// ==========================================================
	// reset values
	localparam logic [31:0] GPC_FSEL_RST = 32'h00000000;
	localparam logic [7:0] GPC_DIR_RST = 8'h00;
	localparam logic [7:0] GPC_OUT_RST = 8'h00;
	localparam logic [31:0] GPC_ZERO = 32'h00000000;
endpackage

/* File: gpc_fsel.sv */
/*
 * gpc_fsel: one port function-select register, two bits per pin.
 * assumes: the caller decodes the address and qualifies the write strobe.
 */
`timescale 1ns/1ps
module gpc_fsel import gpc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] value_o,
	output logic [2*GPC_SEL_PINS-1:0] func_o
);
	// ==========================================================
	// storage
	logic [31:0] fsel;
	wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
		{8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [31:0] next_fsel = ((fsel & ~lane_mask) | (wdata_i & lane_mask))
		& GPC_FSEL_MASK;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			fsel <= GPC_FSEL_RST;
		else if (we_i)
			fsel <= next_fsel;
	end

	assign value_o = fsel;
	// ==========================================================
	// pin n sits at bits 4n+1:4n
	genvar n;
	for (n = 0; n < GPC_SEL_PINS; n++) begin : g_pin
		assign func_o[2*n +: 2] = fsel[GPC_FSEL_STRIDE*n +: 2];
	end

	a_fsel_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(fsel & ~GPC_FSEL_MASK) == GPC_ZERO)
		else $error("reserved select bits not zero");
endmodule // gpc_fsel

/* File: gpc_port.sv */
/*
 * gpc_port: direction, output data and reset snapshot of one 8-pin port.
 * assumes: set, clear and data writes arrive as one-cycle strobes.
 */
`timescale 1ns/1ps
module gpc_port import gpc_pkg::*; #(
	parameter int PINS = GPC_PINS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic dat_we_i,
	input wire logic set_we_i,
	input wire logic clr_we_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] wdata_i,
	input wire logic [PINS-1:0] pin_i,
	output logic [PINS-1:0] pin_o,
	output logic [PINS-1:0] pin_oe_o,
	output logic [31:0] dat_o
);
	// ==========================================================
	// state
	logic [PINS-1:0] dir;
	logic [PINS-1:0] dout;
	logic [PINS-1:0] snap;
	logic [PINS-1:0] din;
	logic was_rst;

	wire [PINS-1:0] w_dir = wdata_i[GPC_DIR_LSB +: PINS];
	wire [PINS-1:0] w_out = wdata_i[GPC_OUT_LSB +: PINS];
	wire dir_lane = dat_we_i & sel_i[3];
	wire out_lane = sel_i[2];
	// a write of 0 to set or clear leaves the bit alone
	wire [PINS-1:0] set_m = (set_we_i & out_lane) ? w_out : '0;
	wire [PINS-1:0] clr_m = (clr_we_i & out_lane) ? w_out : '0;
	wire [PINS-1:0] base_out = (dat_we_i & out_lane) ? w_out : dout;
	wire [PINS-1:0] next_dout = (base_out | set_m) & ~clr_m;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir <= GPC_DIR_RST;
			dout <= GPC_OUT_RST;
		end else begin
			if (dir_lane)
				dir <= w_dir;
			dout <= next_dout;
		end
	end

	// pins are caught on the first edge after reset is released
	always_ff @(posedge clk_i) begin
		was_rst <= rst_i;
		din <= pin_i;
		if (was_rst && !rst_i)
			snap <= pin_i;
	end

	assign pin_o = dout;
	assign pin_oe_o = dir;
	assign dat_o = {dir, dout, snap, din};

	a_set_drives_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(set_we_i && out_lane && !clr_we_i) |=> ((pin_o & $past(w_out))
		== $past(w_out)))
		else $error("set write did not raise output");
	a_clr_drives_low: assert property (@(posedge clk_i) disable iff (rst_i)
		(clr_we_i && out_lane) |=> ((pin_o & $past(w_out)) == '0))
		else $error("clear write did not lower output");
	a_idle_out_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		!(dat_we_i || set_we_i || clr_we_i) |=> $stable(pin_o))
		else $error("output changed without a write");
	a_dir_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		dir_lane |=> pin_oe_o == $past(w_dir))
		else $error("direction not taken");
	a_input_sampled: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> dat_o[GPC_IN_LSB +: PINS] == $past(pin_i))
		else $error("input field not one cycle behind pins");
	a_snap_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		!was_rst |=> $stable(snap))
		else $error("reset snapshot moved");
endmodule // gpc_port

/* File: gpc_board.sv */
/*
 * gpc_board: board side of the three 8-bit ports.
 * assumes: the bench supplies what the board drives on undriven pins.
 */
`timescale 1ns/1ps
module gpc_board import gpc_pkg::*; (
	input wire logic [GPC_PORTS*GPC_PINS-1:0] drv_i,
	input wire logic [GPC_PORTS*GPC_PINS-1:0] oe_i,
	input wire logic [GPC_PORTS*GPC_PINS-1:0] ext_i,
	output logic [GPC_PORTS*GPC_PINS-1:0] level_o
);
	// ==========================================================
	// wire resolution
	// a driven pin shows the block's level, a released one the board's
	assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // gpc_board

/* File: gpc_port_pin_control_test.sv */
/*
 * gpc_port_pin_control_test: register and pin checks of gpc_top.
 * assumes: gpc_board resolves the pins; classic Wishbone master here.
 */
`timescale 1ns/1ps
module gpc_port_pin_control_test import gpc_pkg::*; ;
	// ==========================================================
	// signals
	localparam logic [23:0] EXT0 = 24'h5a3c96;
	localparam logic [23:0] EXT1 = 24'hc3e718;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'hf;
	logic [23:0] ext = EXT0;
	logic [31:0] dat_o;
	logic ack_o;
	logic err_o;
	logic [23:0] pin_i;
	logic [23:0] pin_o;
	logic [23:0] pin_oe_o;
	logic [13:0] p1_func_o;
	logic [13:0] p2_func_o;
	logic [31:0] q;
	logic [31:0] base;
	logic [7:0] sn;
	logic [7:0] lv;
	logic e;
	int fails = 0;
	int cmp_count = 0;
	always #5 clk_i = ~clk_i;
	gpc_top u_gpc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(pin_oe_o), .p1_func_o(p1_func_o),
		.p2_func_o(p2_func_o));
	gpc_board u_gpc_board (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext),
		.level_o(pin_i));
	// ==========================================================
	// tasks
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	// entered just after a rising edge; holds until ack or err sampled
	task automatic wb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] rq, output logic re);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rq = dat_o;
		re = err_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
	endtask
	// ==========================================================
	// sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		ext <= EXT1;
		@(posedge clk_i);
		chk({8'h0, pin_oe_o}, 32'h0);
		chk({8'h0, pin_o}, 32'h0);
		chk({18'h0, p1_func_o}, 32'h0);
		chk({18'h0, p2_func_o}, 32'h0);
		wb(1'b1, GPC_P1_FSEL, 32'hffffffff, q, e);
		wb(1'b0, GPC_P1_FSEL, 32'h0, q, e);
		chk(q, 32'h03333333);
		chk({18'h0, p1_func_o}, 32'h3fff);
		wb(1'b1, GPC_P2_FSEL, 32'hfedfcdce, q, e);
		wb(1'b0, GPC_P2_FSEL, 32'h0, q, e);
		chk(q, 32'h02130102);
		chk({18'h0, p2_func_o}, 32'h2712);
		for (int p = 0; p < 3; p++) begin
			base = GPC_P0_DAT + 32'h10 * p;
			sn = EXT0[8*p +: 8];
			lv = EXT1[8*p +: 8];
			wb(1'b0, base, 32'h0, q, e);
			chk(q, {16'h0, sn, lv});
			wb(1'b1, base, 32'hf0a5ffff, q, e);
			wb(1'b0, base, 32'h0, q, e);
			chk(q, {16'hf0a5, sn, 8'ha0 | (lv & 8'h0f)});
			chk({24'h0, pin_oe_o[8*p +: 8]}, 32'hf0);
			wb(1'b1, base + 32'h4, 32'hff0fffff, q, e);
			wb(1'b0, base + 32'h4, 32'h0, q, e);
			chk(q, 32'h0);
			chk({24'h0, pin_o[8*p +: 8]}, 32'haf);
			wb(1'b1, base + 32'h8, 32'hffa0ffff, q, e);
			wb(1'b0, base + 32'h8, 32'h0, q, e);
			chk(q, 32'h0);
			chk({24'h0, pin_o[8*p +: 8]}, 32'h0f);
			wb(1'b0, base, 32'h0, q, e);
			chk(q, {16'hf00f, sn, lv & 8'h0f});
		end
		// unmapped place answers with err and no data
		wb(1'b0, 32'hffff0d00, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		tally_and_finish();
	end
endmodule // gpc_port_pin_control_test
